//--- cpu_reset_interrupt_sequencer.sv
// reset, interrupt entry, return and debug halt sequencing of the core
// assumes: memory answers a read in the same cycle as the strobe, the
// executor reports instruction boundaries and the debug link delivers
// decoded commands as one-cycle pulses
//
// Functional notes
// - accumulator keeps its value through reset
// - index pointer is high and low halves
// - reset clears index high, keeps low
// - some writes touch only index low half
// - index low supports full byte operations
// - reset abandons current instruction at once
// - start only after sources done, pin released
// - six cycles: vector high, low, queue fill
// - interrupts wait for the instruction boundary
// - interrupt reuses trap sequence, captured vector
// - push PC low, PC high, X, A, flags
// - set mask bit after flags are stacked
// - fetch vector high byte then low byte
// - one free bus cycle after vector fetch
// - fill three queue bytes from vector address
// - halt opcode enters active background mode
// - leave background only by reset or command
// - halt opcode in memory acts as breakpoint
// - stack-relative address is stack plus offset
`timescale 1ns/1ps
module cpu_reset_interrupt_sequencer #(
  parameter logic [15:0] TRAP_VEC = seq_pkg::TRAP_VECTOR,
  parameter logic [7:0] HALT_CODE = seq_pkg::HALT_OPCODE
) (
  input wire logic core_clk,
  input wire logic rst,
  // reset source status
  input wire logic resetSourceDone,
  input wire logic resetPin_n,
  // executor side
  input wire logic instrDone,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] nextOpcode,
  input wire logic trapRequest,
  input wire logic returnRequest,
  input wire logic regWrite,
  input wire logic [2:0] regSelect,
  input wire logic [15:0] regValue,
  input wire logic xOpValid,
  input wire logic [3:0] xOpCode,
  input wire logic [15:0] operandOffset,
  // interrupt sources
  input wire logic irqRequest,
  input wire logic [15:0] irqVector,
  // debug host commands
  input wire logic debugCommand,
  input wire logic [1:0] debugCmd,
  // memory bus
  output logic [15:0] busAddr,
  output logic busRead,
  output logic busWrite,
  output logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  // visible state
  output logic [7:0] accumulator,
  output logic [7:0] indexHigh,
  output logic [7:0] indexLow,
  output logic [7:0] conditionFlags,
  output logic [15:0] programCounter,
  output logic [15:0] stackPointer,
  output logic [7:0] queueByte0,
  output logic [7:0] queueByte1,
  output logic [7:0] queueByte2,
  output logic [15:0] indexedAddress,
  output logic [15:0] stackOffsetAddress,
  output logic executing,
  output logic inBackground
);

  // ==========================================================
  // state and counters
  seq_pkg::seq_state_type state; // sequencer state
  seq_pkg::seq_state_type next_state; // its next value
  logic [2:0] step; // push and pull byte counter
  logic [1:0] fillIndex; // queue fill position
  logic [15:0] vectorAddr; // vector captured at sequence start
  logic stepPending; // single step requested by the host

  // ==========================================================
  // decode
  wire released = !rst && resetSourceDone && resetPin_n;
  wire inRun = (state == seq_pkg::ST_RUN);
  wire boundary = inRun && instrDone;
  wire takeIrq = irqRequest && !conditionFlags[seq_pkg::MASK_BIT];
  wire haltHit = (nextOpcode == HALT_CODE);
  wire lastStep = (step == seq_pkg::STACK_BYTES - 3'h1);
  wire lastFill = (fillIndex == seq_pkg::QUEUE_BYTES - 2'h1);
  wire [15:0] stackUp = stackPointer + 16'h0001;
  wire [15:0] fillAddr = programCounter + {14'h0000, fillIndex};
  wire [15:0] vectorNext = vectorAddr + 16'h0001;
  wire [15:0] indexPair = {indexHigh, indexLow};
  wire endPush = (state == seq_pkg::ST_PUSH) && lastStep;
  wire endPull = (state == seq_pkg::ST_PULL) && lastStep;
  wire cmdExit = (state == seq_pkg::ST_BACKGROUND) && debugCommand;
  wire regPort = inRun && regWrite;
  wire xPort = inRun && xOpValid;

  // ==========================================================
  // byte unit on the index low half
  logic [7:0] xResult; // operation result
  logic xCarry; // carry produced
  index_byte_alu u_xalu (
    .operand(indexLow),
    .carryIn(conditionFlags[seq_pkg::CARRY_BIT]),
    .op(xOpCode),
    .result(xResult),
    .carryOut(xCarry)
  );

  // ==========================================================
  // address generators
  offset_adder16 #(.WIDTH(16)) u_index_add (
    .base(indexPair),
    .offset(operandOffset),
    .sum(indexedAddress)
  );
  offset_adder16 #(.WIDTH(16)) u_stack_add (
    .base(stackPointer),
    .offset(operandOffset),
    .sum(stackOffsetAddress)
  );

  // ==========================================================
  // byte pushed in each push step
  logic [7:0] pushByte;
  always_comb begin
    unique case (step)
      3'h0: pushByte = programCounter[7:0];
      3'h1: pushByte = programCounter[15:8];
      3'h2: pushByte = indexLow;
      3'h3: pushByte = accumulator;
      default: pushByte = conditionFlags;
    endcase
  end

  // ==========================================================
  // bus drive, combinational from state
  always_comb begin
    busAddr = 16'h0000;
    busRead = 1'b0;
    busWrite = 1'b0;
    busWdata = 8'h00;
    unique case (state)
      seq_pkg::ST_VEC_HI: begin
        busAddr = vectorAddr;
        busRead = 1'b1;
      end
      seq_pkg::ST_VEC_LO: begin
        busAddr = vectorNext;
        busRead = 1'b1;
      end
      seq_pkg::ST_FILL: begin
        busAddr = fillAddr;
        busRead = 1'b1;
      end
      seq_pkg::ST_PUSH: begin
        busAddr = stackPointer;
        busWrite = 1'b1;
        busWdata = pushByte;
      end
      seq_pkg::ST_PULL: begin
        busAddr = stackUp;
        busRead = 1'b1;
      end
      default: begin
        busAddr = 16'h0000; // idle and free cycles leave the bus quiet
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      seq_pkg::ST_HOLD: begin
        if (released) begin
          next_state = seq_pkg::ST_VEC_HI;
        end
      end
      seq_pkg::ST_VEC_HI: next_state = seq_pkg::ST_VEC_LO;
      seq_pkg::ST_VEC_LO: next_state = seq_pkg::ST_FREE;
      seq_pkg::ST_FREE: next_state = seq_pkg::ST_FILL;
      seq_pkg::ST_FILL: begin
        if (lastFill) begin
          next_state = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (boundary) begin
          if (trapRequest || takeIrq) begin
            next_state = seq_pkg::ST_PUSH;
          end else if (returnRequest) begin
            next_state = seq_pkg::ST_PULL;
          end else if (stepPending || haltHit) begin
            next_state = seq_pkg::ST_BACKGROUND;
          end
        end
      end
      seq_pkg::ST_PUSH: begin
        if (lastStep) begin
          next_state = seq_pkg::ST_VEC_HI;
        end
      end
      seq_pkg::ST_PULL: begin
        if (lastStep) begin
          next_state = seq_pkg::ST_FREE;
        end
      end
      seq_pkg::ST_BACKGROUND: begin
        if (debugCommand) begin
          next_state = seq_pkg::ST_RUN;
        end
      end
      default: next_state = seq_pkg::ST_HOLD; // illegal code recovers
    endcase
  end

  // ==========================================================
  // state, counters, vector capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= seq_pkg::ST_HOLD;
      step <= 3'h0;
      fillIndex <= 2'h0;
      vectorAddr <= seq_pkg::RESET_VECTOR;
      stepPending <= 1'b0;
    end else begin
      state <= next_state;
      step <= (state == next_state) ? step + 3'h1 : 3'h0;
      fillIndex <= (state == seq_pkg::ST_FILL) ? fillIndex + 2'h1 : 2'h0;
      if (boundary && (trapRequest || takeIrq)) begin
        vectorAddr <= trapRequest ? TRAP_VEC : irqVector;
      end
      if (cmdExit) begin
        stepPending <= (debugCmd == seq_pkg::CMD_STEP);
      end else if (next_state == seq_pkg::ST_BACKGROUND) begin
        stepPending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // accumulator: never touched by reset
  always_ff @(posedge core_clk) begin
    if (regPort && regSelect == seq_pkg::SEL_ACC) begin
      accumulator <= regValue[7:0];
    end else if (state == seq_pkg::ST_PULL && step == 3'h1) begin
      accumulator <= busRdata;
    end
  end

  // ==========================================================
  // index low half: never touched by reset
  always_ff @(posedge core_clk) begin
    if (regPort && regSelect == seq_pkg::SEL_XLOW) begin
      indexLow <= regValue[7:0];
    end else if (regPort && regSelect == seq_pkg::SEL_INDEX16) begin
      indexLow <= regValue[7:0];
    end else if (xPort) begin
      indexLow <= xResult;
    end else if (state == seq_pkg::ST_PULL && step == 3'h2) begin
      indexLow <= busRdata;
    end
  end

  // ==========================================================
  // index high half: cleared while reset is held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      indexHigh <= seq_pkg::INDEX_HIGH_RESET;
    end else if (regPort && regSelect == seq_pkg::SEL_INDEX16) begin
      indexHigh <= regValue[15:8];
    end else if (regPort && regSelect == seq_pkg::SEL_XHIGH) begin
      indexHigh <= regValue[7:0];
    end
  end

  // ==========================================================
  // condition flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conditionFlags <= seq_pkg::FLAGS_RESET;
    end else if (endPush) begin
      conditionFlags[seq_pkg::MASK_BIT] <= 1'b1;
    end else if (state == seq_pkg::ST_PULL && step == 3'h0) begin
      conditionFlags <= busRdata;
    end else if (regPort && regSelect == seq_pkg::SEL_FLAGS) begin
      conditionFlags <= regValue[7:0];
    end else if (xPort) begin
      conditionFlags[seq_pkg::CARRY_BIT] <= xCarry;
    end
  end

  // ==========================================================
  // stack pointer: post-decrement on push, pre-increment on pull
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stackPointer <= seq_pkg::STACK_RESET;
    end else if (state == seq_pkg::ST_PUSH) begin
      stackPointer <= stackPointer - 16'h0001;
    end else if (state == seq_pkg::ST_PULL) begin
      stackPointer <= stackUp;
    end else if (regPort && regSelect == seq_pkg::SEL_STACK) begin
      stackPointer <= regValue;
    end
  end

  // ==========================================================
  // program counter: executor hands next address at boundary
  always_ff @(posedge core_clk) begin
    if (state == seq_pkg::ST_VEC_HI) begin
      programCounter[15:8] <= busRdata;
    end else if (state == seq_pkg::ST_VEC_LO) begin
      programCounter[7:0] <= busRdata;
    end else if (state == seq_pkg::ST_PULL && step == 3'h3) begin
      programCounter[15:8] <= busRdata;
    end else if (endPull) begin
      programCounter[7:0] <= busRdata;
    end else if (boundary) begin
      programCounter <= nextPc;
    end
  end

  // ==========================================================
  // instruction queue, filled at the end of each entry
  always_ff @(posedge core_clk) begin
    if (state == seq_pkg::ST_FILL) begin
      unique case (fillIndex)
        2'h0: queueByte0 <= busRdata;
        2'h1: queueByte1 <= busRdata;
        default: queueByte2 <= busRdata;
      endcase
    end
  end

  // ==========================================================
  // status
  assign executing = inRun;
  assign inBackground = (state == seq_pkg::ST_BACKGROUND);

endmodule

//--- seq_pkg.sv
// shared constants for the reset and interrupt sequencer of the 8-bit core
// assumes: every user writes seq_pkg::name, nothing is imported
package seq_pkg;

  // ==========================================================
  // vectors, reset values and the halt opcode
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
  localparam logic [15:0] STACK_RESET = 16'h00FF;
  localparam logic [7:0] FLAGS_RESET = 8'h08;
  localparam logic [7:0] INDEX_HIGH_RESET = 8'h00;
  localparam logic [7:0] HALT_OPCODE = 8'h00;

  // ==========================================================
  // condition flag bit positions
  localparam int MASK_BIT = 3;
  localparam int CARRY_BIT = 0;

  // ==========================================================
  // sequence lengths
  localparam logic [2:0] STACK_BYTES = 3'h5;
  localparam logic [1:0] QUEUE_BYTES = 2'h3;

  // ==========================================================
  // register select for the write port
  localparam logic [2:0] SEL_ACC = 3'h0;
  localparam logic [2:0] SEL_XLOW = 3'h1;
  localparam logic [2:0] SEL_XHIGH = 3'h2;
  localparam logic [2:0] SEL_INDEX16 = 3'h3;
  localparam logic [2:0] SEL_FLAGS = 3'h4;
  localparam logic [2:0] SEL_STACK = 3'h5;

  // ==========================================================
  // index low half operations
  localparam logic [3:0] XOP_CLR = 4'h0;
  localparam logic [3:0] XOP_INC = 4'h1;
  localparam logic [3:0] XOP_DEC = 4'h2;
  localparam logic [3:0] XOP_COM = 4'h3;
  localparam logic [3:0] XOP_NEG = 4'h4;
  localparam logic [3:0] XOP_LSL = 4'h5;
  localparam logic [3:0] XOP_LSR = 4'h6;
  localparam logic [3:0] XOP_ASR = 4'h7;
  localparam logic [3:0] XOP_ROL = 4'h8;
  localparam logic [3:0] XOP_ROR = 4'h9;

  // ==========================================================
  // debug host commands
  localparam logic [1:0] CMD_RESUME = 2'h0;
  localparam logic [1:0] CMD_STEP = 2'h1;
  localparam logic [1:0] CMD_TAGGED = 2'h2;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_HOLD = 4'h0,
    ST_VEC_HI = 4'h1,
    ST_VEC_LO = 4'h2,
    ST_FREE = 4'h3,
    ST_FILL = 4'h4,
    ST_RUN = 4'h5,
    ST_PUSH = 4'h6,
    ST_BACKGROUND = 4'h7,
    ST_PULL = 4'h8
  } seq_state_type;

endpackage

//--- index_byte_alu.sv
// single-operand byte unit used on the index low half
// assumes: purely combinational, the caller registers the result
`timescale 1ns/1ps
module index_byte_alu (
  input wire logic [7:0] operand,
  input wire logic carryIn,
  input wire logic [3:0] op,
  output logic [7:0] result,
  output logic carryOut
);

  // ==========================================================
  // operation select
  always_comb begin
    result = operand;
    carryOut = carryIn;
    unique case (op)
      seq_pkg::XOP_CLR: result = 8'h00;
      seq_pkg::XOP_INC: result = operand + 8'h01;
      seq_pkg::XOP_DEC: result = operand - 8'h01;
      seq_pkg::XOP_COM: begin
        result = ~operand;
        carryOut = 1'b1; // complement always sets carry
      end
      seq_pkg::XOP_NEG: begin
        result = 8'h00 - operand;
        carryOut = (operand != 8'h00);
      end
      seq_pkg::XOP_LSL: begin
        result = {operand[6:0], 1'b0};
        carryOut = operand[7];
      end
      seq_pkg::XOP_LSR: begin
        result = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      seq_pkg::XOP_ASR: begin
        result = {operand[7], operand[7:1]};
        carryOut = operand[0];
      end
      seq_pkg::XOP_ROL: begin
        result = {operand[6:0], carryIn};
        carryOut = operand[7];
      end
      seq_pkg::XOP_ROR: begin
        result = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      default: begin
        result = operand; // unused codes leave the byte alone
        carryOut = carryIn;
      end
    endcase
  end

endmodule

//--- offset_adder16.sv
// 16-bit base plus 16-bit offset, wrapping at the top of memory
// assumes: combinational, used for indexed and stack-relative modes
`timescale 1ns/1ps
module offset_adder16 #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] base,
  input wire logic [WIDTH-1:0] offset,
  output logic [WIDTH-1:0] sum
);

  // ==========================================================
  // top carry dropped: addresses wrap
  assign sum = base + offset;

endmodule

//--- mem_model.sv
// memory partner: byte array answering reads in the strobe cycle
// assumes: strobes are sampled on the rising edge of core_clk
`timescale 1ns/1ps
module mem_model (
  input wire logic core_clk,
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata
);
  // ==========================================================
  // storage
  // full space: vectors and stack
  logic [7:0] mem [0:65535];
  // idle bus shows the last byte inverted
  logic [7:0] lastByte = 8'h00;
  assign busRdata = busRead ? mem[busAddr] : ~lastByte;
  // writes land on the sampling edge
  always @(posedge core_clk) begin
    if (busWrite) begin
      mem[busAddr] <= busWdata;
    end
    if (busRead) begin
      lastByte <= mem[busAddr];
    end
  end
endmodule

//--- cpu_seq_chk.sv
// checker: reset, entry, vector fetch and debug-halt timing
// assumes: bound onto the sequencer, sees only its ports
`timescale 1ns/1ps
module cpu_seq_chk #(
  parameter logic [15:0] TRAP_VEC = 16'hFFFC,
  parameter logic [7:0] HALT_CODE = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resetSourceDone,
  input wire logic resetPin_n,
  input wire logic instrDone,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] nextOpcode,
  input wire logic trapRequest,
  input wire logic returnRequest,
  input wire logic [15:0] operandOffset,
  input wire logic irqRequest,
  input wire logic debugCommand,
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] indexHigh,
  input wire logic [7:0] indexLow,
  input wire logic [7:0] conditionFlags,
  input wire logic [15:0] stackPointer,
  input wire logic [15:0] stackOffsetAddress,
  input wire logic executing,
  input wire logic inBackground
);
  // ==========================================================
  // helpers
  // held registers are unknown before the first run
  logic ranOnce = 1'b0;
  always @(posedge core_clk) begin
    if (executing) begin
      ranOnce <= 1'b1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // three fills, then run
  sequence fill3;
    busRead [*3] ##1 executing;
  endsequence
  // vector high, low, a free cycle, fill from the fetched vector
  sequence vecFetch(logic [15:0] v);
    busRead && busAddr == v ##1 busRead && busAddr == v + 16'h0001
    ##1 !busRead && !busWrite
    ##1 busAddr == {$past(busRdata, 3), $past(busRdata, 2)} ##0 fill3;
  endsequence
  // ==========================================================
  // assertions
  acc_keep_a: assert property (disable iff (1'b0)
    rst && ranOnce |=> accumulator == $past(accumulator))
    else $error("accumulator altered by reset");
  index_reset_a: assert property (disable iff (1'b0)
    rst && ranOnce |=> indexHigh == 8'h00 && indexLow == $past(indexLow))
    else $error("index halves wrong after reset");
  reset_abort_a: assert property (disable iff (1'b0)
    rst |=> !executing && !busRead && !busWrite)
    else $error("reset did not stop the core");
  reset_wait_a: assert property (
    !executing && !inBackground && !busRead && !busWrite
    && !(resetSourceDone && resetPin_n) |=> !busRead)
    else $error("fetch before reset concluded");
  reset_vector_a: assert property (
    busRead && busAddr == 16'hFFFE |-> vecFetch(16'hFFFE))
    else $error("reset fetch sequence wrong");
  trap_push_a: assert property (
    executing && instrDone && trapRequest |=>
    busWrite && busWdata == $past(nextPc[7:0])
    ##1 busWrite && busWdata == $past(nextPc[15:8], 2) ##1 busWrite [*3])
    else $error("stacking order wrong");
  trap_vector_a: assert property (
    executing && instrDone && trapRequest |=>
    ##5 conditionFlags[seq_pkg::MASK_BIT] ##0 vecFetch(TRAP_VEC))
    else $error("trap vector sequence wrong");
  irq_wait_a: assert property (
    executing && !instrDone |=> executing)
    else $error("left run state off a boundary");
  halt_enter_a: assert property (
    executing && instrDone && nextOpcode == HALT_CODE && !trapRequest
    && !returnRequest && !(irqRequest && !conditionFlags[seq_pkg::MASK_BIT])
    |=> inBackground) else $error("halt opcode not honoured");
  bg_hold_a: assert property (
    inBackground && !debugCommand |=> inBackground)
    else $error("left background without command");
  bg_leave_a: assert property (
    inBackground && debugCommand |=> executing)
    else $error("command did not resume");
  stack_rel_a: assert property (
    stackOffsetAddress == stackPointer + operandOffset)
    else $error("stack relative address wrong");
endmodule

//--- cpu_reset_interrupt_sequencer_test.sv
// testbench: reset, index ops, trap, interrupt, return, debug halt
// assumes: mem_model as memory, checker bound at the foot
`timescale 1ns/1ps
module cpu_reset_interrupt_sequencer_test;
  // ==========================================================
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic resetSourceDone = 1'b0;
  logic resetPin_n = 1'b0;
  logic instrDone = 1'b0;
  logic [15:0] nextPc = 16'h0000;
  logic [7:0] nextOpcode = 8'h01;
  logic trapRequest = 1'b0;
  logic returnRequest = 1'b0;
  logic regWrite = 1'b0;
  logic [2:0] regSelect = 3'h0;
  logic [15:0] regValue = 16'h0000;
  logic xOpValid = 1'b0;
  logic [3:0] xOpCode = 4'h0;
  logic [15:0] operandOffset = 16'h0100;
  logic irqRequest = 1'b0;
  logic [15:0] irqVector = 16'h3000;
  logic debugCommand = 1'b0;
  logic [1:0] debugCmd = 2'h0;
  logic [15:0] busAddr, programCounter, stackPointer;
  logic [15:0] indexedAddress, stackOffsetAddress;
  logic busRead, busWrite, executing, inBackground;
  logic [7:0] busWdata, busRdata, accumulator, indexHigh, indexLow;
  logic [7:0] conditionFlags, queueByte0, queueByte1, queueByte2;
  int failCount = 0;
  int testsRun = 0;
  // x low after each op on 0x81 with carry set
  logic [7:0] expX [10] = '{8'h00, 8'h82, 8'h80, 8'h7E, 8'h7F,
                            8'h02, 8'h40, 8'hC0, 8'h03, 8'hC0};
  cpu_reset_interrupt_sequencer cpu_reset_interrupt_sequencer_i (
    .core_clk, .rst, .resetSourceDone, .resetPin_n, .instrDone, .nextPc,
    .nextOpcode, .trapRequest, .returnRequest, .regWrite, .regSelect,
    .regValue, .xOpValid, .xOpCode, .operandOffset, .irqRequest,
    .irqVector, .debugCommand, .debugCmd, .busAddr, .busRead, .busWrite,
    .busWdata, .busRdata, .accumulator, .indexHigh, .indexLow,
    .conditionFlags, .programCounter, .stackPointer, .queueByte0,
    .queueByte1, .queueByte2, .indexedAddress, .stackOffsetAddress,
    .executing, .inBackground);
  mem_model mem_model_i (.core_clk, .busAddr, .busRead, .busWrite,
    .busWdata, .busRdata);
  always #12.5 core_clk = ~core_clk;
  // ==========================================================
  // shared tasks; inputs move 2 ns after the rising edge
  task tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task check(input logic ok, input string msg);
    testsRun++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask
  task wrapUp;
    $display("comparisons %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for the run state; a hang ends the run
  task waitExec(input int n);
    int i;
    i = 0;
    while (executing !== 1'b1 && i < n) begin
      tick();
      i++;
    end
    if (executing !== 1'b1) begin
      check(1'b0, "no run state");
      wrapUp();
    end
  endtask
  // idle cycle after each write
  task wr(input logic [2:0] sel, input logic [15:0] val);
    regWrite = 1'b1;
    regSelect = sel;
    regValue = val;
    tick();
    regWrite = 1'b0;
    tick();
  endtask
  task boundary(input logic [15:0] pc, input logic [7:0] op,
                          input logic trap, input logic ret);
    instrDone = 1'b1;
    nextPc = pc;
    nextOpcode = op;
    trapRequest = trap;
    returnRequest = ret;
    tick();
    instrDone = 1'b0;
    trapRequest = 1'b0;
    returnRequest = 1'b0;
  endtask
  task sendCmd(input logic [1:0] cmd);
    debugCmd = cmd;
    debugCommand = 1'b1;
    tick();
    debugCommand = 1'b0;
    check(executing === 1'b1 && inBackground === 1'b0, "no resume");
  endtask
  // ==========================================================
  // scenarios
  task testPowerUp;
    tick(8);
    rst = 1'b0;
    tick(3);
    check(busRead === 1'b0 && executing === 1'b0, "early fetch");
    resetSourceDone = 1'b1;
    tick(3);
    check(busRead === 1'b0, "fetch, pin held");
    resetPin_n = 1'b1;
    waitExec(12);
    check(programCounter === 16'h1234, "reset vector");
    check({queueByte0, queueByte1, queueByte2} === 24'hA1_B2C3, "q");
    $display("power-up test done");
  endtask
  task testIndex;
    wr(seq_pkg::SEL_INDEX16, 16'h7781);
    check(indexedAddress === 16'h7881, "indexed address");
    check(stackOffsetAddress === 16'h01FF, "stack relative");
    for (int k = 0; k < 10; k++) begin
      wr(seq_pkg::SEL_XLOW, 16'h0081);
      wr(seq_pkg::SEL_FLAGS, 16'h0009);
      xOpValid = 1'b1;
      xOpCode = 4'(k);
      tick();
      xOpValid = 1'b0;
      tick();
      check(indexLow === expX[k] && indexHigh === 8'h77, "x op");
    end
    $display("index test done");
  endtask
  task testMidReset;
    wr(seq_pkg::SEL_ACC, 16'h005A);
    rst = 1'b1;
    tick();
    check(executing === 1'b0 && busRead === 1'b0, "no abort");
    tick();
    rst = 1'b0;
    check(accumulator === 8'h5A, "acc changed");
    check(indexHigh === 8'h00 && indexLow === 8'hC0, "index");
    waitExec(12);
    check(programCounter === 16'h1234, "restart vector");
    $display("mid-run reset test done");
  endtask
  task testTrap;
    wr(seq_pkg::SEL_FLAGS, 16'h0001);
    boundary(16'h1300, 8'h01, 1'b1, 1'b0);
    waitExec(14);
    check({mem_model_i.mem[255], mem_model_i.mem[254], mem_model_i.mem[253],
      mem_model_i.mem[252], mem_model_i.mem[251]} === 40'h00_13C0_5A01,
      "stack");
    check(programCounter === 16'h2000 && queueByte0 === 8'hD1, "vec");
    check(conditionFlags === 8'h09, "mask not set");
    $display("trap test done");
  endtask
  task testIrqReturn;
    irqRequest = 1'b1;
    tick(3);
    check(executing === 1'b1, "irq off boundary");
    boundary(16'h2001, 8'h01, 1'b0, 1'b1);
    waitExec(14);
    check(programCounter === 16'h1300 && conditionFlags === 8'h01
      && stackPointer === 16'h00FF, "return restore");
    boundary(16'h1301, 8'h01, 1'b0, 1'b0);
    waitExec(16);
    irqRequest = 1'b0;
    check(programCounter === 16'h4000 && queueByte0 === 8'hE1
      && mem_model_i.mem[255] === 8'h01, "irq entry");
    $display("interrupt test done");
  endtask
  task testDebug;
    for (int c = 0; c < 3; c++) begin
      boundary(16'h4010, seq_pkg::HALT_OPCODE, 1'b0, 1'b0);
      check(inBackground === 1'b1, "no halt");
      tick(4);
      check(inBackground === 1'b1, "left background");
      sendCmd(2'(c));
      if (c == 1) begin
        boundary(16'h4011, 8'h01, 1'b0, 1'b0);
        check(inBackground === 1'b1, "no step stop");
        sendCmd(seq_pkg::CMD_RESUME);
      end
    end
    $display("debug test done");
  endtask
  initial begin
    mem_model_i.mem[16'hFFFE] = 8'h12;
    mem_model_i.mem[16'hFFFF] = 8'h34;
    mem_model_i.mem[16'h1234] = 8'hA1;
    mem_model_i.mem[16'h1235] = 8'hB2;
    mem_model_i.mem[16'h1236] = 8'hC3;
    mem_model_i.mem[16'hFFFC] = 8'h20;
    mem_model_i.mem[16'hFFFD] = 8'h00;
    mem_model_i.mem[16'h2000] = 8'hD1;
    mem_model_i.mem[16'h3000] = 8'h40;
    mem_model_i.mem[16'h3001] = 8'h00;
    mem_model_i.mem[16'h4000] = 8'hE1;
    testPowerUp();
    testIndex();
    testMidReset();
    testTrap();
    testIrqReturn();
    testDebug();
    wrapUp();
  end
endmodule
bind cpu_reset_interrupt_sequencer cpu_seq_chk #(.TRAP_VEC(TRAP_VEC),
  .HALT_CODE(HALT_CODE)) cpu_seq_chk_i (.core_clk, .rst, .resetSourceDone,
  .resetPin_n, .instrDone, .nextPc, .nextOpcode, .trapRequest,
  .returnRequest, .operandOffset, .irqRequest, .debugCommand, .busAddr,
  .busRead, .busWrite, .busWdata, .busRdata, .accumulator, .indexHigh,
  .indexLow, .conditionFlags, .stackPointer, .stackOffsetAddress,
  .executing, .inBackground);
